/* rtl/lane_cfg_regs.sv */
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`include "lane_cfg_consts.svh"

module lane_cfg_regs
	import lane_cfg_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic      [31:0] prdata,
	output logic             pslverr,
	input  wire logic [7:0]  link_lane_count_mode,
	input  wire logic [3:0]  link_test_pattern_select,
	input  wire logic [7:0]  mode_lane_mask,
	output lane_ctl_s        lane_ctl,
	output logic [3:0]       lane_test_pattern,
	output sync_ctl_s        sync_ctl,
	output logic             serial_link_enable,
	output logic             serdes_power_on,
	output logic [7:0]       downconverter_config
);

	// -----------------------------------------------------------------
	// bus decode
	// -----------------------------------------------------------------
	logic [7:0]  extra_q;
	logic [7:0]  sync_q;
	logic [7:0]  ddc_q;
	logic [7:0]  ctrl_q;
	logic        pready_q;
	logic [31:0] prdata_q;
	logic        pslverr_q;
	lane_ctl_s   lane_q;
	lane_ctl_s   lane_d;
	sync_ctl_s   sync_ctl_q;
	sync_ctl_s   sync_ctl_d;
	logic [3:0]  pat_q;
	logic [3:0]  pat_d;
	logic        link_en_q;
	logic        pwr_q;

	wire access   = psel & penable;
	wire hit_ex   = paddr == `ADDR_EXTRA_LANE;
	wire hit_sy   = paddr == `ADDR_SYNC_MODE;
	wire hit_dd   = paddr == `ADDR_DOWNCONVERTER_CONFIG;
	wire hit_ct   = paddr == `ADDR_LINK_CTRL;
	wire hit_st   = paddr == `ADDR_LANE_STATUS;
	wire mapped   = hit_ex | hit_sy | hit_dd | hit_ct | hit_st;
	wire wr_ok    = access & pwrite & mapped;

	// extra lane and sync mode writes while the link runs would glitch live lane clocks,
	// so they are refused with pslverr instead of being taken
	wire locked   = ctrl_q[`BIT_LINK_ENABLE] & (hit_ex | hit_sy);
	wire err      = ~mapped | (pwrite & locked) | (pwrite & hit_st);

	wire [7:0] rd_byte = hit_ex ? extra_q :
	                     hit_sy ? sync_q  :
	                     hit_dd ? ddc_q   :
	                     hit_ct ? ctrl_q  :
	                     hit_st ? lane_q.ser_clk_en : 8'h00;

	// -----------------------------------------------------------------
	// lane logic
	// -----------------------------------------------------------------
	function automatic logic [7:0] chain_ok(input logic [7:0] en);
		logic [7:0] r;
		r = 8'h00;
		r[0] = en[0];
		for (int i = 1; i < 8; i++) begin
			r[i] = en[i] & r[i-1];
		end
		return r;
	endfunction : chain_ok

	wire       pd_both   = ctrl_q[`BIT_PD_A] & ctrl_q[`BIT_PD_B];
	wire       link_up   = ~pd_both & ctrl_q[`BIT_LINK_ENABLE];
	wire [7:0] extra_sel = {extra_q[7:1], 1'b0};
	// extra lanes are or-ed onto the mode mask, never masking it
	wire [7:0] lane_req  = mode_lane_mask | extra_sel;
	wire [7:0] clk_en    = link_up ? lane_req : 8'h00;
	wire [7:0] ser_req   = mode_lane_mask | (extra_q[`BIT_EXTRA_SER] ? extra_sel : 8'h00);
	wire [7:0] ser_en    = link_up ? (chain_ok(ser_req) & clk_en) : 8'h00;
	wire       ramp_case = (link_test_pattern_select == `TEST_NONE) |
	                       (link_test_pattern_select == `TEST_ALT_RAMP);
	wire [7:0] only_ext  = extra_sel & ~mode_lane_mask;
	wire [7:0] ramp_en   = ramp_case ? (only_ext & ser_en) : 8'h00;
	wire       enc_66    = link_lane_count_mode[`ENC_64B66B_BIT];

	always_comb begin
		lane_d.lane_clk_en = clk_en;
		lane_d.ser_clk_en  = ser_en;
		lane_d.ramp_sel    = ramp_en;
		pat_d              = link_test_pattern_select;
		sync_ctl_d.cmd     = 8'h00;
		if (!enc_66) begin
			sync_ctl_d.hdr = SH_IDLE;
		end else if (sync_q[1:0] == `SYNC_MODE_FEC) begin
			sync_ctl_d.hdr = SH_FEC;
		end else begin
			// reserved codes fall back to the crc default
			sync_ctl_d.hdr = SH_CRC;
		end
	end

	// -----------------------------------------------------------------
	// registers
	// -----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			extra_q <= `RST_EXTRA_LANE;
			sync_q  <= `RST_SYNC_MODE;
			ddc_q   <= `RST_DOWNCONVERTER_CONFIG;
			ctrl_q  <= `RST_LINK_CTRL;
		end else if (wr_ok && !err) begin
			// full bytes stored: reserved bits read back unchanged
			if (hit_ex) extra_q <= pwdata[7:0];
			if (hit_sy) sync_q  <= pwdata[7:0];
			if (hit_dd) ddc_q   <= pwdata[7:0];
			if (hit_ct) ctrl_q  <= pwdata[7:0];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pready_q  <= 1'b0;
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= psel & ~penable;
			prdata_q  <= {24'h00_0000, rd_byte};
			pslverr_q <= psel & ~penable & err;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			lane_q     <= '0;
			sync_ctl_q <= '{hdr: SH_CRC, cmd: 8'h00};
			pat_q      <= 4'h0;
			link_en_q  <= 1'b0;
			pwr_q      <= 1'b0;
		end else begin
			lane_q     <= lane_d;
			sync_ctl_q <= sync_ctl_d;
			pat_q      <= pat_d;
			link_en_q  <= link_up;
			pwr_q      <= ~pd_both;
		end
	end

	assign pready               = pready_q;
	assign prdata               = prdata_q;
	assign pslverr              = pslverr_q;
	assign lane_ctl             = lane_q;
	assign lane_test_pattern    = pat_q;
	assign sync_ctl             = sync_ctl_q;
	assign serial_link_enable   = link_en_q;
	assign serdes_power_on      = pwr_q;
	assign downconverter_config = ddc_q;

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	sequence s_write_ex;
		psel && penable && pwrite && pready && hit_ex && !ctrl_q[0];
	endsequence

	a_extra_write_taken: assert property (s_write_ex |=> extra_q == $past(pwdata[7:0]))
		else $error("extra lane write lost");
	a_locked_no_write: assert property (locked && pwrite && access |=> $stable(extra_q) && $stable(sync_q))
		else $error("write taken while link enabled");
	a_ser_chain: assert property (lane_q.ser_clk_en[3] |-> lane_q.ser_clk_en[2:0] == 3'b111)
		else $error("serializer clocked without lower lanes");
	a_ser_needs_bit: assert property (!extra_q[0] && !mode_lane_mask[4] |=> !lane_q.ser_clk_en[4])
		else $error("serializer on without enable bit");
	a_extra_clock: assert property (link_up && extra_q[5] |=> lane_q.lane_clk_en[5])
		else $error("extra lane clock missing");
	a_power_gate: assert property (pd_both |=> lane_q == '0 ##1 !serdes_power_on)
		else $error("lanes on while powered down");
	a_cmd_zero: assert property (sync_ctl.cmd == 8'h00)
		else $error("command field not zero");
	a_fec_select: assert property (enc_66 && sync_q[1:0] == 2'h2 |=> sync_ctl.hdr == SH_FEC)
		else $error("fec not selected");
	a_no_66_idle: assert property (!enc_66 |=> sync_ctl.hdr == SH_IDLE)
		else $error("sync mode used outside 64b66b");
	a_ramp_extra: assert property (ramp_case && (only_ext & ser_en) != 8'h00 |=> lane_q.ramp_sel != 8'h00)
		else $error("ramp missing on extra lane");
	a_reset_zero: assert property ($rose(rst_n) |-> extra_q == 8'h00)
		else $error("extra lane not reset");
	a_pattern_follow: assert property (1'b1 |=> pat_q == $past(link_test_pattern_select))
		else $error("pattern not forwarded");

	// -----------------------------------------------------------------
	// bus protocol checks
	// -----------------------------------------------------------------
	sequence s_setup;
		psel && !penable;
	endsequence

	sequence s_sync_write;
		psel && penable && pwrite && pready && hit_sy && !ctrl_q[`BIT_LINK_ENABLE];
	endsequence

	a_ready_after_setup: assert property (
		s_setup |=> pready)
		else $error("no ready after setup");

	a_ready_one_cycle: assert property (
		pready |=> !pready)
		else $error("ready held too long");

	a_err_with_ready: assert property (
		pslverr |-> pready)
		else $error("error without ready");

	a_read_upper_zero: assert property (
		pready |-> prdata[31:8] == 24'h00_0000)
		else $error("read data upper bits set");

	a_unmapped_err: assert property (
		psel && !penable && !mapped |=> pslverr && prdata == 32'h0000_0000)
		else $error("unmapped access not refused");

	a_status_read_only: assert property (
		psel && !penable && pwrite && hit_st |=> pslverr)
		else $error("status write not refused");

	a_locked_refused: assert property (
		psel && !penable && pwrite && locked |=> pslverr)
		else $error("locked write not refused");

	a_sync_write_taken: assert property (
		s_sync_write |=> sync_q == $past(pwdata[7:0]))
		else $error("sync mode write lost");

	// -----------------------------------------------------------------
	// lane enable checks
	// -----------------------------------------------------------------
	sequence s_link_up;
		link_up;
	endsequence

	a_extra_lane_low: assert property (
		s_link_up ##0 extra_q[1] |=> lane_q.lane_clk_en[1])
		else $error("extra lane one clock missing");

	a_extra_lane_top: assert property (
		s_link_up ##0 extra_q[7] |=> lane_q.lane_clk_en[7])
		else $error("extra lane seven clock missing");

	a_mode_lanes_kept: assert property (
		s_link_up |=> (lane_q.lane_clk_en & $past(mode_lane_mask)) == $past(mode_lane_mask))
		else $error("mode lane dropped");

	a_clocks_only: assert property (
		s_link_up ##0 !extra_q[`BIT_EXTRA_SER] |=>
			(lane_q.ser_clk_en & ~$past(mode_lane_mask)) == 8'h00)
		else $error("extra serializer on in clock only scope");

	a_ser_scope_on: assert property (
		s_link_up ##0 extra_q[1:0] == 2'b11 && mode_lane_mask[0] |=> lane_q.ser_clk_en[1])
		else $error("extra serializer not enabled");

	a_ser_has_clock: assert property (
		(lane_q.ser_clk_en & ~lane_q.lane_clk_en) == 8'h00)
		else $error("serializer on without lane clock");

	a_ser_chain_top: assert property (
		lane_q.ser_clk_en[7] |-> lane_q.ser_clk_en[6:0] == 7'h7f)
		else $error("top serializer clocked without lower lanes");

	a_ser_no_base: assert property (
		!mode_lane_mask[0] |=> lane_q.ser_clk_en == 8'h00)
		else $error("serializer clocked without lane zero");

	a_link_down_dark: assert property (
		!link_up |=> lane_q.lane_clk_en == 8'h00 && lane_q.ser_clk_en == 8'h00)
		else $error("lane clocks on while link down");

	a_ramp_off: assert property (
		!ramp_case |=> lane_q.ramp_sel == 8'h00)
		else $error("ramp forced outside ramp cases");

	a_ramp_not_mode: assert property (
		s_link_up |=> (lane_q.ramp_sel & $past(mode_lane_mask)) == 8'h00)
		else $error("ramp forced on mode lane");

	// -----------------------------------------------------------------
	// sync word and power checks
	// -----------------------------------------------------------------
	sequence s_enc_66;
		enc_66;
	endsequence

	a_crc_default: assert property (
		s_enc_66 ##0 sync_q[1:0] != `SYNC_MODE_FEC |=> sync_ctl.hdr == SH_CRC)
		else $error("crc not selected");

	a_cmd_held_zero: assert property (
		1'b1 |=> sync_ctl.cmd == 8'h00 && $stable(sync_ctl.cmd))
		else $error("command field moved");

	a_both_down_off: assert property (
		pd_both |=> !serdes_power_on && !serial_link_enable)
		else $error("serial side powered with both channels down");

	a_one_up_on: assert property (
		!pd_both |=> serdes_power_on)
		else $error("serial side off with a channel up");

	a_link_out_follow: assert property (
		1'b1 |=> serial_link_enable == $past(link_up))
		else $error("link enable output stale");

	a_reset_state: assert property (
		$rose(rst_n) |-> sync_q == 8'h00 && lane_q == '0 && !pready)
		else $error("state not cleared by reset");

	a_reserved_kept: assert property (
		s_sync_write |=> sync_q[7:2] == $past(pwdata[7:2]))
		else $error("reserved bits not kept");

endmodule : lane_cfg_regs

/* rtl/lane_cfg_consts.svh */
`ifndef LANE_CFG_CONSTS_SVH
`define LANE_CFG_CONSTS_SVH

// -----------------------------------------------------------------
// register indices; one word each, byte address is index times four
// -----------------------------------------------------------------
`define IDX_EXTRA_LANE      10'h20b
`define IDX_SYNC_MODE       10'h20f
`define IDX_DOWNCONVERTER_CONFIG         10'h210
`define ADDR_EXTRA_LANE     {`IDX_EXTRA_LANE, 2'b00}
`define ADDR_SYNC_MODE      {`IDX_SYNC_MODE, 2'b00}
`define ADDR_DOWNCONVERTER_CONFIG        {`IDX_DOWNCONVERTER_CONFIG, 2'b00}
`define ADDR_LINK_CTRL      12'h0300
`define ADDR_LANE_STATUS    12'h0304

// -----------------------------------------------------------------
// reset values and field positions
// -----------------------------------------------------------------
`define RST_EXTRA_LANE      8'h00
`define RST_SYNC_MODE       8'h00
`define RST_DOWNCONVERTER_CONFIG         8'h00
`define RST_LINK_CTRL       8'h00
`define BIT_EXTRA_SER       0
`define BIT_LINK_ENABLE     0
`define BIT_PD_A            1
`define BIT_PD_B            2
`define SYNC_MODE_CRC       2'h0
`define SYNC_MODE_FEC       2'h2
`define TEST_NONE           4'h0
`define TEST_RAMP           4'h4
`define TEST_ALT_RAMP       4'h5
`define ENC_64B66B_BIT      5

`endif

/* rtl/lane_cfg_pkg.sv */
package lane_cfg_pkg;

	typedef enum logic [1:0] {
		SH_CRC,
		SH_FEC,
		SH_IDLE
	} sync_hdr_e;

	typedef struct packed {
		logic [7:0] lane_clk_en;
		logic [7:0] ser_clk_en;
		logic [7:0] ramp_sel;
	} lane_ctl_s;

	typedef struct packed {
		sync_hdr_e  hdr;
		logic [7:0] cmd;
	} sync_ctl_s;

endpackage : lane_cfg_pkg

/* sim/serial_lane_extra_and_sync_config_tb.sv */
`timescale 1ns/1ps
`include "lane_cfg_consts.svh"
module serial_lane_extra_and_sync_config_tb
	import lane_cfg_pkg::*;
;
	logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, link_en, pwr_on, rd_err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd_data;
	logic [7:0]  lmode, mask, ddc;
	logic [3:0]  tsel, tpat;
	lane_ctl_s   lane_ctl;
	sync_ctl_s   sync_ctl;
	int          err_total, total_checks;
	typedef struct packed {
		logic [7:0] mask;
		logic [3:0] tsel;
		logic [7:0] lmode, extra, sync, clk, ser, ramp;
		sync_hdr_e  hdr;
	} row_s;
	// mask, test, mode, extra, sync, lane clk, ser clk, ramp, header
	row_s rows [5] = '{
		'{8'h01, 4'h0, 8'h20, 8'h07, 8'h00, 8'h07, 8'h07, 8'h06, SH_CRC},
		'{8'h01, 4'h5, 8'h20, 8'h0b, 8'hfe, 8'h0b, 8'h03, 8'h02, SH_FEC},
		'{8'h0f, 4'h4, 8'h20, 8'hf0, 8'h01, 8'hff, 8'h0f, 8'h00, SH_CRC},
		'{8'h03, 4'h0, 8'h00, 8'hfd, 8'h02, 8'hff, 8'hff, 8'hfc, SH_IDLE},
		'{8'h01, 4'h3, 8'h20, 8'h05, 8'h03, 8'h05, 8'h01, 8'h00, SH_CRC}};

	lane_cfg_regs u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .link_lane_count_mode(lmode), .link_test_pattern_select(tsel),
		.mode_lane_mask(mask), .lane_ctl(lane_ctl), .lane_test_pattern(tpat),
		.sync_ctl(sync_ctl), .serial_link_enable(link_en), .serdes_power_on(pwr_on),
		.downconverter_config(ddc));

	// ------------------------------
	// shared tasks
	// ------------------------------
	task check(input logic [31:0] got, input logic [31:0] exp, input string m);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask : check

	// waits for ready as long as it takes; only the watchdog ends a hang
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		check(pready, 1, "ready");
		rd_data = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wrap_up;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : wrap_up

	// ------------------------------
	// clock, watchdog, sequence
	// ------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	initial begin
		repeat (3000) @(posedge clk_sys);
		err_total++;
		wrap_up();
	end

	initial begin
		{rst_n, psel, penable, pwrite, paddr, pwdata, lmode, mask, tsel} = '0;
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		apb(0, `ADDR_EXTRA_LANE, 0);
		check(rd_data, 0, "extra reset");
		check(lane_ctl, 0, "lanes reset");
		foreach (rows[i]) begin
			apb(1, `ADDR_LINK_CTRL, 0);
			apb(1, `ADDR_EXTRA_LANE, {24'h0000_00, rows[i].extra});
			check(rd_err, 0, "extra accepted");
			apb(1, `ADDR_SYNC_MODE, {24'h0000_00, rows[i].sync});
			apb(1, `ADDR_LINK_CTRL, 1);
			mask <= rows[i].mask;
			tsel <= rows[i].tsel;
			lmode <= rows[i].lmode;
			repeat (3) @(posedge clk_sys);
			check(lane_ctl.lane_clk_en, rows[i].clk, "lane clk");
			check(lane_ctl.ser_clk_en, rows[i].ser, "ser clk");
			check(lane_ctl.ramp_sel, rows[i].ramp, "ramp");
			check(tpat, rows[i].tsel, "pattern");
			check(sync_ctl.hdr, rows[i].hdr, "header");
			check(sync_ctl.cmd, 0, "command");
			apb(0, `ADDR_SYNC_MODE, 0);
			check(rd_data, rows[i].sync, "sync readback");
			apb(0, `ADDR_LANE_STATUS, 0);
			check(rd_data, rows[i].ser, "status");
		end
		apb(1, `ADDR_EXTRA_LANE, 0);
		check(rd_err, 1, "extra refused");
		apb(1, `ADDR_SYNC_MODE, 2);
		check(rd_err, 1, "sync refused");
		apb(0, `ADDR_EXTRA_LANE, 0);
		check(rd_data, 32'h0000_0005, "extra kept");
		apb(0, 12'h0208, 0);
		check(rd_err, 1, "unmapped error");
		check(rd_data, 32'h0000_0000, "unmapped data");
		apb(1, `ADDR_LANE_STATUS, 1);
		check(rd_err, 1, "status write");
		apb(1, `ADDR_DOWNCONVERTER_CONFIG, 32'hffff_ff81);
		apb(0, `ADDR_DOWNCONVERTER_CONFIG, 0);
		check(rd_data, 32'h0000_0081, "ddc readback");
		check(ddc, 8'h81, "ddc out");
		apb(1, `ADDR_LINK_CTRL, 3);
		repeat (2) @(posedge clk_sys);
		check({link_en, pwr_on}, 2'b11, "one channel down");
		apb(1, `ADDR_LINK_CTRL, 7);
		repeat (2) @(posedge clk_sys);
		check({link_en, pwr_on}, 2'b00, "both down");
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		apb(0, `ADDR_EXTRA_LANE, 0);
		check(rd_data, 0, "extra second reset");
		wrap_up();
	end
endmodule : serial_lane_extra_and_sync_config_tb
